/* bench/serial_node_model.sv */
// remote serial node: drives frames onto rxd and captures frames from txd
`timescale 1ns/1ps
`default_nettype none
module serial_node_model #(
	parameter int BT = 32
) (
	// clock
	input  wire logic clk,
	// serial lines
	input  wire logic txd,
	output var  logic rxd
);
	logic [12*BT-1:0] smp;
	logic [9:0]       got;
	int               r;
	int               e;
	logic [9:0]       rxQ[$];

	initial rxd = 1'b1;

	// ==========================================
	// sender: every bit held one full bit time, line back high after
	task automatic sendFrame(input logic [7:0] b, input logic nine, input logic nb,
		input logic stp);
		logic [10:0] f;
		f = nb ? {stp, nine, b, 1'b0} : {1'b1, stp, b, 1'b0};
		for (int i = 0; i < 10 + int'(nb); i++) begin
			rxd = f[i];
			repeat (BT) @(posedge clk);
			#1;
		end
		rxd = 1'b1;
		repeat (BT) @(posedge clk);
		#1;
	endtask : sendFrame

	// ==========================================
	// receiver: the first start bit may be short, so the bit grid is
	// found from the first rising edge, which always lies on it
	always begin
		@(negedge txd);
		for (int i = 0; i < 12 * BT; i++) begin
			@(posedge clk);
			smp[i] = txd;
		end
		r = 1;
		while (r < 12 * BT - 1 && !smp[r]) r++;
		e = ((r - 1) % BT) + 1;
		for (int j = 0; j < 10; j++) got[j] = smp[e + j * BT + BT / 2];
		rxQ.push_back(got);
	end
endmodule : serial_node_model
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin nCompared++; if ((g) !== (x)) begin numErrors++; \
	$display("[ERR] %0t got %h expected %h", $time, g, x); end end
module testbench;
	import uart_serial_port_pkg::*;
	localparam logic [7:0] RELOAD = 8'hF0;
	localparam int         BT     = 2 * (256 - RELOAD);
	localparam logic [7:0] CA     = SERIAL_PORT_CONTROL_ADDR;
	localparam logic [7:0] DA     = SERIAL_DATA_BUFFER_ADDR;
	logic       clk;
	logic       reset;
	logic [7:0] regAddr;
	logic       regWrite;
	logic [7:0] regWriteData;
	logic [7:0] regReadData;
	logic       timerTick;
	logic [7:0] baudTimerReload;
	logic       portIrqEnable;
	logic       portIrq;
	logic       rxd;
	logic       txd;
	int         numErrors;
	int         nCompared;
	int         seed;
	logic [7:0] v;
	logic [7:0] w;
	logic [7:0] dat;
	logic [7:0] lastRx;
	logic [9:0] fr;
	logic [4:0] c;
	logic       acc;
	// case bits: mode, filter, enable, stop or ninth bit, flag preset
	logic [4:0] rxCases [9] = '{5'h04, 5'h0C, 5'h0E, 5'h02, 5'h07, 5'h14, 5'h1C, 5'h1E, 5'h17};

	uart_serial_port_control i_uart_serial_port_control (.clk(clk), .reset(reset),
		.regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData),
		.regReadData(regReadData), .timerTick(timerTick), .baudTimerReload(baudTimerReload),
		.portIrqEnable(portIrqEnable), .portIrq(portIrq), .rxd(rxd), .txd(txd));
	serial_node_model #(.BT(BT)) i_serial_node_model (.clk(clk), .txd(txd), .rxd(rxd));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ==========================================
	// register port tasks, entered and left just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr = a;
		regWriteData = d;
		regWrite = 1'b1;
		@(posedge clk);
		#1 regWrite = 1'b0;
		// one idle edge, so a following write never raises the strobe just lowered
		@(posedge clk);
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		regAddr = a;
		@(posedge clk);
		#1 d = regReadData;
	endtask : rd

	task automatic give_verdict;
		if (numErrors == 0 && nCompared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict

	// whole run is some 5200 cycles; this leaves a wide margin
	initial begin
		repeat (40000) @(posedge clk);
		numErrors++;
		give_verdict();
	end

	// ==========================================
	// main sequence
	initial begin
		reset = 1'b1;
		regAddr = 8'h00;
		regWrite = 1'b0;
		regWriteData = 8'h00;
		timerTick = 1'b1;
		baudTimerReload = RELOAD;
		portIrqEnable = 1'b0;
		lastRx = DATA_RESET;
		seed = $urandom(32'hea6b);
		repeat (4) @(posedge clk);
		#1 reset = 1'b0;
		rd(CA, v); `CHK(v, CONTROL_RESET)
		rd(DA, v); `CHK(v, DATA_RESET)
		rd(8'h97, v); `CHK(v, 8'h00)
		`CHK(txd, 1'b1)
		for (int k = 0; k < 4; k++) begin
			w = 8'($urandom);
			wr(CA, w);
			rd(CA, v); `CHK(v, w | 8'h40)
		end
		wr(CA, 8'h00);
		// the transmit timer's first count from reset is a long one; let it reach
		// its reload period so no start bit is longer than one bit time
		repeat (300) @(posedge clk);
		#1;
		for (int k = 0; k < 4; k++) begin
			w = {k[1], 3'h0, k[0], 3'h0};
			dat = 8'($urandom);
			portIrqEnable = 1'($urandom);
			wr(CA, w);
			wr(DA, dat);
			rd(DA, v); `CHK(v, lastRx)
			v = 8'h00;
			for (int i = 0; i < 20 * BT && !v[TX_DONE_BIT]; i++) rd(CA, v);
			`CHK(txd, 1'b1)
			`CHK(v, w | 8'h42)
			`CHK(portIrq, portIrqEnable)
			repeat (BT) @(posedge clk);
			#1;
			rd(CA, v); `CHK(v[TX_DONE_BIT], 1'b1)
			for (int i = 0; i < 20 * BT && i_serial_node_model.rxQ.size() == 0; i++) @(posedge clk);
			#1;
			fr = i_serial_node_model.rxQ.pop_front();
			`CHK(fr, k[1] ? {1'b1, k[0], dat} : {2'h3, dat})
			wr(CA, 8'h00);
		end
		for (int k = 0; k < 9; k++) begin
			c = rxCases[k];
			w = {c[4], 1'b0, c[3], c[2], 3'h0, c[0]};
			acc = c[2] && !c[0] && (!c[3] || c[1]);
			dat = 8'($urandom);
			portIrqEnable = 1'($urandom);
			wr(CA, w);
			i_serial_node_model.sendFrame(dat, c[1], c[4], c[4] | c[1]);
			if (acc) lastRx = dat;
			rd(CA, v); `CHK(v, acc ? (w | 8'h41 | {5'h00, c[1], 2'h0}) : (w | 8'h40))
			rd(DA, v); `CHK(v, lastRx)
			`CHK(portIrq, portIrqEnable & (acc | c[0]))
		end
		give_verdict();
	end
endmodule : testbench
`default_nettype wire

/* common/uart_serial_port_pkg.sv */
// constants and types shared by the serial port control block
package uart_serial_port_pkg;
	// ==========================================
	// register addresses
	localparam logic [7:0] SERIAL_PORT_CONTROL_ADDR = 8'h98;
	localparam logic [7:0] SERIAL_DATA_BUFFER_ADDR  = 8'h99;
	// ==========================================
	// control register field positions
	localparam int FRAME_MODE_BIT    = 7;
	localparam int READS_ONE_BIT     = 6;
	localparam int FILTER_ENABLE_BIT = 5;
	localparam int RECEIVE_EN_BIT    = 4;
	localparam int TX_NINTH_BIT      = 3;
	localparam int RX_NINTH_BIT      = 2;
	localparam int TX_DONE_BIT       = 1;
	localparam int RX_DONE_BIT       = 0;
	// ==========================================
	// reset values and the timer top count
	localparam logic [7:0] CONTROL_RESET = 8'h40;
	localparam logic [7:0] DATA_RESET    = 8'h00;
	localparam logic [7:0] TIMER_RESET   = 8'h00;
	localparam logic [7:0] TIMER_TOP     = 8'hFF;
	// ==========================================
	// frame layout
	localparam logic [2:0] LAST_DATA_INDEX = 3'h7;
	typedef enum logic [4:0] {
		IDLE_S  = 5'b0_0001,
		START_S = 5'b0_0010,
		DATA_S  = 5'b0_0100,
		NINTH_S = 5'b0_1000,
		STOP_S  = 5'b1_0000
	} frame_state_t;
endpackage : uart_serial_port_pkg

/* rtl/uart_serial_port_control.sv */
// asynchronous serial port: control register, data buffer, transmitter and receiver
//
// Contract
// - control bit 7 selects 8-bit framing at 0, 9-bit framing at 1.
// - control bit 6 always reads one; writes to it are ignored.
// - 8-bit mode with filter on accepts a frame only if stop bit is high.
// - 9-bit mode with filter on accepts a frame only if ninth bit is one.
// - receive enable at 0 blocks reception, at 1 allows it.
// - 9-bit mode sends the transmit-ninth-bit control as ninth bit.
// - accepted frame stores stop bit (8-bit) or ninth bit (9-bit).
// - transmit-complete sets at start of the stop bit.
// - hardware never clears the two complete flags; software clears them.
// - receive-complete sets when the stop bit of an accepted frame is sampled.
// - enabled port interrupt follows the complete flags.
// - writing the data buffer loads and starts transmission.
// - reading the data buffer returns the receive latch only.
// - bit rate is baud timer overflow rate divided by two, separate receive copy.
// - start condition forces reload of the receive bit timer.
// - frame is start, eight data bits LSB first, optional ninth, stop.
// - a frame arriving while receive-complete is set is discarded.
`timescale 1ns/1ps
`default_nettype none
module uart_serial_port_control (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// special function register port
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrite,
	input  wire logic [7:0] regWriteData,
	output var  logic [7:0] regReadData,
	// baud timer inputs
	input  wire logic       timerTick,
	input  wire logic [7:0] baudTimerReload,
	// interrupt
	input  wire logic       portIrqEnable,
	output var  logic       portIrq,
	// serial line
	input  wire logic       rxd,
	output var  logic       txd
);
	import uart_serial_port_pkg::*;

	// ==========================================
	// helpers
	function automatic logic [7:0] timerNext(input logic [7:0] cnt, input logic [7:0] rel);
		timerNext = (cnt == TIMER_TOP) ? rel : cnt + 8'h01;
	endfunction : timerNext

	function automatic logic overflowNow(input logic [7:0] cnt, input logic tick);
		overflowNow = tick && (cnt == TIMER_TOP);
	endfunction : overflowNow

	// ==========================================
	// control register
	logic         frameMode_q, filterEnable_q, receiveEnable_q;
	logic         txNinth_q, rxNinth_q, txDone_q, rxDone_q;
	logic [7:0]   rxLatch_q, txShift_q, rxShift_q;
	logic [7:0]   txTimer_q, rxTimer_q;
	logic         txHalf_q, rxHalf_q, rxPrev_q;
	logic [2:0]   txIndex_q, rxIndex_q;
	logic         rxNinthBit_q;
	frame_state_t txState_q, rxState_q;
	logic         ctrlWrite, dataWrite, txTick, rxSample, startSeen;
	logic         txDoneSet, rxAccept, frameOk;

	assign ctrlWrite = regWrite && (regAddr == SERIAL_PORT_CONTROL_ADDR);
	assign dataWrite = regWrite && (regAddr == SERIAL_DATA_BUFFER_ADDR);

	always_ff @(posedge clk) begin
		if (reset) begin
			frameMode_q     <= CONTROL_RESET[FRAME_MODE_BIT];
			filterEnable_q  <= CONTROL_RESET[FILTER_ENABLE_BIT];
			receiveEnable_q <= CONTROL_RESET[RECEIVE_EN_BIT];
			txNinth_q       <= CONTROL_RESET[TX_NINTH_BIT];
		end else if (ctrlWrite) begin
			frameMode_q     <= regWriteData[FRAME_MODE_BIT];
			filterEnable_q  <= regWriteData[FILTER_ENABLE_BIT];
			receiveEnable_q <= regWriteData[RECEIVE_EN_BIT];
			txNinth_q       <= regWriteData[TX_NINTH_BIT];
		end
	end

	// flags: a hardware set in the same cycle as a software write wins
	always_ff @(posedge clk) begin
		if (reset) begin
			txDone_q <= CONTROL_RESET[TX_DONE_BIT];
			rxDone_q <= CONTROL_RESET[RX_DONE_BIT];
		end else begin
			txDone_q <= txDoneSet || (ctrlWrite ? regWriteData[TX_DONE_BIT] : txDone_q);
			rxDone_q <= rxAccept || (ctrlWrite ? regWriteData[RX_DONE_BIT] : rxDone_q);
		end
	end

	// receive ninth bit is software writable and loaded by an accepted frame
	always_ff @(posedge clk) begin
		if (reset) begin
			rxNinth_q <= CONTROL_RESET[RX_NINTH_BIT];
		end else if (rxAccept) begin
			rxNinth_q <= frameMode_q ? rxNinthBit_q : rxd;
		end else if (ctrlWrite) begin
			rxNinth_q <= regWriteData[RX_NINTH_BIT];
		end
	end

	// read data is registered: valid one cycle after the address is presented
	always_ff @(posedge clk) begin
		if (reset) begin
			regReadData <= DATA_RESET;
		end else if (regAddr == SERIAL_PORT_CONTROL_ADDR) begin
			regReadData <= {frameMode_q, 1'b1, filterEnable_q, receiveEnable_q,
				txNinth_q, rxNinth_q, txDone_q, rxDone_q};
		end else if (regAddr == SERIAL_DATA_BUFFER_ADDR) begin
			regReadData <= rxLatch_q;
		end else begin
			regReadData <= DATA_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			portIrq <= 1'b0;
		end else begin
			portIrq <= portIrqEnable && (txDone_q || rxDone_q);
		end
	end

	// ==========================================
	// bit timers: overflow divided by two gives one bit time
	always_ff @(posedge clk) begin
		if (reset) begin
			txTimer_q <= TIMER_RESET;
			txHalf_q  <= 1'b0;
		end else if (timerTick) begin
			txTimer_q <= timerNext(txTimer_q, baudTimerReload);
			if (txTimer_q == TIMER_TOP) begin
				txHalf_q <= ~txHalf_q;
			end
		end
	end
	assign txTick = overflowNow(txTimer_q, timerTick) && txHalf_q;

	// receive copy; a start edge reloads it so sampling lands mid-bit
	always_ff @(posedge clk) begin
		if (reset) begin
			rxTimer_q <= TIMER_RESET;
			rxHalf_q  <= 1'b0;
		end else if (startSeen) begin
			rxTimer_q <= baudTimerReload;
			rxHalf_q  <= 1'b0;
		end else if (timerTick) begin
			rxTimer_q <= timerNext(rxTimer_q, baudTimerReload);
			if (rxTimer_q == TIMER_TOP) begin
				rxHalf_q <= ~rxHalf_q;
			end
		end
	end
	assign rxSample = overflowNow(rxTimer_q, timerTick) && !rxHalf_q;

	// ==========================================
	// transmitter
	assign txDoneSet = txTick && (((txState_q == DATA_S) && (txIndex_q == LAST_DATA_INDEX)
		&& !frameMode_q) || (txState_q == NINTH_S));

	always_ff @(posedge clk) begin
		if (reset) begin
			txState_q <= IDLE_S;
			txShift_q <= DATA_RESET;
			txIndex_q <= 3'h0;
			txd       <= 1'b1;
		end else if (dataWrite) begin
			// a write restarts the frame; software should wait for transmit-complete
			txShift_q <= regWriteData;
			txIndex_q <= 3'h0;
			txState_q <= START_S;
			txd       <= 1'b0;
		end else if (txTick) begin
			case (txState_q)
				START_S: begin
					txState_q <= DATA_S;
					txd       <= txShift_q[0];
				end
				DATA_S: begin
					if (txIndex_q == LAST_DATA_INDEX) begin
						txState_q <= frameMode_q ? NINTH_S : STOP_S;
						txd       <= frameMode_q ? txNinth_q : 1'b1;
					end else begin
						txIndex_q <= txIndex_q + 3'h1;
						txd       <= txShift_q[txIndex_q + 3'h1];
					end
				end
				NINTH_S: begin
					txState_q <= STOP_S;
					txd       <= 1'b1;
				end
				STOP_S: begin
					txState_q <= IDLE_S;
					txd       <= 1'b1;
				end
				default: begin
					txState_q <= IDLE_S;
					txd       <= 1'b1;
				end
			endcase
		end
	end

	// ==========================================
	// receiver
	assign startSeen = (rxState_q == IDLE_S) && receiveEnable_q && rxPrev_q && !rxd;
	assign frameOk   = !filterEnable_q || (frameMode_q ? rxNinthBit_q : rxd);
	assign rxAccept  = rxSample && (rxState_q == STOP_S) && !rxDone_q && frameOk;

	always_ff @(posedge clk) begin
		if (reset) begin
			rxPrev_q <= 1'b1;
		end else begin
			rxPrev_q <= rxd;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rxState_q    <= IDLE_S;
			rxShift_q    <= DATA_RESET;
			rxIndex_q    <= 3'h0;
			rxNinthBit_q <= 1'b0;
		end else if (startSeen) begin
			rxState_q <= START_S;
			rxIndex_q <= 3'h0;
		end else if (rxSample) begin
			case (rxState_q)
				START_S: begin
					// a start bit that is high again at mid-bit was a glitch
					rxState_q <= rxd ? IDLE_S : DATA_S;
				end
				DATA_S: begin
					rxShift_q <= {rxd, rxShift_q[7:1]};
					rxIndex_q <= rxIndex_q + 3'h1;
					if (rxIndex_q == LAST_DATA_INDEX) begin
						rxState_q <= frameMode_q ? NINTH_S : STOP_S;
					end
				end
				NINTH_S: begin
					rxNinthBit_q <= rxd;
					rxState_q    <= STOP_S;
				end
				default: begin
					rxState_q <= IDLE_S;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rxLatch_q <= DATA_RESET;
		end else if (rxAccept) begin
			rxLatch_q <= rxShift_q;
		end
	end

	// ==========================================
	// checks
	txIdleHigh_a: assert property (@(posedge clk) disable iff (reset)
		(txState_q == IDLE_S) |-> txd)
		else $error("transmit line low while idle");

	controlReadsOne_a: assert property (@(posedge clk) disable iff (reset)
		(regAddr == SERIAL_PORT_CONTROL_ADDR) |=> regReadData[READS_ONE_BIT])
		else $error("control bit 6 did not read one");

	bufferRead_a: assert property (@(posedge clk) disable iff (reset)
		(regAddr == SERIAL_DATA_BUFFER_ADDR) |=> (regReadData == $past(rxLatch_q)))
		else $error("buffer read is not the receive latch");

	flagsSticky_a: assert property (@(posedge clk) disable iff (reset)
		($fell(txDone_q) || $fell(rxDone_q)) |-> $past(ctrlWrite))
		else $error("complete flag cleared without a software write");

	txDoneMoment_a: assert property (@(posedge clk) disable iff (reset)
		$rose(txDone_q) && !$past(ctrlWrite) |-> (txState_q == STOP_S) && txd)
		else $error("transmit-complete not at the stop bit");

	rxDiscard_a: assert property (@(posedge clk) disable iff (reset)
		rxDone_q && !ctrlWrite |=> $stable(rxLatch_q))
		else $error("receive latch overwritten while flag set");

	rxDisabled_a: assert property (@(posedge clk) disable iff (reset)
		(rxState_q == IDLE_S) && !receiveEnable_q |=> (rxState_q == IDLE_S))
		else $error("reception started while disabled");

	writeStarts_a: assert property (@(posedge clk) disable iff (reset)
		dataWrite |=> (txState_q == START_S) && !txd && (txShift_q == $past(regWriteData)))
		else $error("data write did not start a frame");

	irqFollows_a: assert property (@(posedge clk) disable iff (reset)
		portIrqEnable && (txDone_q || rxDone_q) ##1 portIrqEnable |-> portIrq)
		else $error("port interrupt missing");

	ninthSent_a: assert property (@(posedge clk) disable iff (reset)
		(txState_q == NINTH_S) && $changed(txState_q) |-> (txd == $past(txNinth_q)))
		else $error("ninth bit differs from control");

	filterStop_a: assert property (@(posedge clk) disable iff (reset)
		rxAccept && !frameMode_q && filterEnable_q |-> rxd)
		else $error("frame with low stop bit accepted");
endmodule : uart_serial_port_control
`default_nettype wire
